// >>> core/sil_pkg.sv
package sil_pkg;

  // register indices, byte address is four times the index
  localparam logic [7:0] SIL_IDX_INT_CFG = 8'h03;
  localparam logic [7:0] SIL_IDX_EVENT_EN = 8'h04;
  localparam logic [7:0] SIL_IDX_MODE_ONE = 8'h05;
  localparam logic [7:0] SIL_IDX_MODE_TWO = 8'h06;
  localparam logic [7:0] SIL_IDX_STATUS = 8'h10;
  localparam logic [7:0] SIL_IDX_PROX_ONE_TH = 8'h11;
  localparam logic [7:0] SIL_IDX_PROX_TWO_TH = 8'h12;
  localparam logic [7:0] SIL_IDX_PROX_HYST = 8'h13;
  localparam logic [7:0] SIL_IDX_PROX_PERSIST = 8'h14;

  localparam int SIL_ADDR_W = 10;

  // interrupt configuration fields
  localparam int SIL_POS_OUT_EN = 0;
  localparam int SIL_POS_DEASSERT_MODE = 1;

  // event enable / flag positions
  localparam int SIL_FLAG_W = 6;
  localparam int SIL_POS_PROX_ONE = 2;
  localparam int SIL_POS_PROX_TWO = 3;
  localparam int SIL_POS_COMMAND = 5;
  localparam logic [5:0] SIL_FLAG_USED = 6'h2c;

  // mode field positions
  localparam int SIL_POS_PROX_ONE_SEL = 4;
  localparam int SIL_POS_PROX_TWO_SEL = 6;
  localparam int SIL_POS_COMMAND_SEL = 2;

  // reset values
  localparam logic [1:0] SIL_RST_INT_CFG = 2'h0;
  localparam logic [5:0] SIL_RST_EVENT_EN = 6'h00;
  localparam logic [7:0] SIL_RST_MODE = 8'h00;
  localparam logic [7:0] SIL_RST_TH = 8'h00;
  localparam logic [7:0] SIL_RST_HYST = 8'h00;
  localparam logic [7:0] SIL_RST_PERSIST = 8'h00;

  // error codes in a response carry this bit
  localparam int SIL_POS_RESP_ERR = 7;

  typedef enum logic [1:0] {
    SIL_SEL_EVERY = 2'h0,
    SIL_SEL_CROSS = 2'h1,
    SIL_SEL_BAD = 2'h2,
    SIL_SEL_ABOVE = 2'h3
  } sil_sel_t;

  typedef struct packed {
    logic valid;
    logic [15:0] value;
  } sil_sample_t;

  typedef struct packed {
    logic valid;
    logic [7:0] code;
  } sil_resp_t;

  function automatic logic [SIL_ADDR_W-1:0] silAddr(input logic [7:0] idx);
    silAddr = {idx, 2'b00};
  endfunction

  // compressed code: upper nibble exponent, lower nibble mantissa
  function automatic logic [19:0] silExpand(input logic [7:0] code);
    logic [19:0] mant;
    mant = {15'h0000, 1'b1, code[3:0]};
    if (code[7:4] == 4'h0) begin
      silExpand = {16'h0000, code[3:0]};
    end else begin
      silExpand = mant << (code[7:4] - 4'h1);
    end
  endfunction

endpackage

// >>> core/sil_prox_channel.sv
`timescale 1ns/1ps
module sil_prox_channel (
  input wire logic sysClk,
  input wire logic rstN,
  input wire sil_pkg::sil_sample_t sample,
  input wire logic eventEn,
  input wire logic [1:0] eventSel,
  input wire logic [7:0] thresholdCode,
  input wire logic [7:0] hysteresisCode,
  input wire logic [7:0] persistCount,
  output logic setFlag
);
  import sil_pkg::*;

  logic aboveQ, aboveD;
  logic [7:0] runQ, runD;
  logic setFlagQ, setFlagD;
  logic [20:0] hiLevel;
  logic [19:0] loLevel, thLin, hyLin;
  logic candidate;
  logic [8:0] runNext;

  always_comb begin
    thLin = silExpand(thresholdCode);
    hyLin = silExpand(hysteresisCode);
    hiLevel = {1'b0, thLin} + {1'b0, hyLin};
    loLevel = (thLin > hyLin) ? thLin - hyLin : 20'h00000;
    // hysteresis band: leave the state only past the far edge
    candidate = aboveQ ? ({4'h0, sample.value} >= loLevel)
                       : ({5'h00, sample.value} > hiLevel);
    runNext = {1'b0, runQ} + 9'h001;
    aboveD = aboveQ;
    runD = runQ;
    if (sample.valid) begin
      if (candidate != aboveQ) begin
        // persistence of zero behaves as one sample
        if (runNext >= {1'b0, persistCount} || persistCount == 8'h00) begin
          aboveD = candidate;
          runD = 8'h00;
        end else begin
          runD = runNext[7:0];
        end
      end else begin
        runD = 8'h00;
      end
    end
    setFlagD = 1'b0;
    if (sample.valid && eventEn) begin
      unique case (sil_sel_t'(eventSel))
        SIL_SEL_EVERY: setFlagD = 1'b1;
        SIL_SEL_CROSS: setFlagD = aboveD != aboveQ;
        SIL_SEL_ABOVE: setFlagD = aboveD;
        SIL_SEL_BAD: setFlagD = 1'b0;
      endcase
    end
  end

  always_ff @(posedge sysClk or negedge rstN) begin
    if (!rstN) begin
      aboveQ <= 1'b0;
      runQ <= 8'h00;
      setFlagQ <= 1'b0;
    end else begin
      aboveQ <= aboveD;
      runQ <= runD;
      setFlagQ <= setFlagD;
    end
  end

  assign setFlag = setFlagQ;

endmodule

// >>> core/sil_irq_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - pin driven only while output enable set
// - pin asserts when flags AND enables nonzero
// - mode zero: writing one clears that flag
// - channel one every-sample flag when enabled
// - channel one flag on threshold crossing
// - channel one flag while above threshold
// - channel two every-sample flag when enabled
// - channel two flag on threshold crossing
// - channel two flag while above threshold
// - hysteresis and persistence gate threshold flags
// - thresholds and hysteresis are compressed codes
// - command flag on every new response
// - command mode one: only new errors
module sil_irq_core (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sil_pkg::SIL_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sil_pkg::sil_sample_t proxOneSample,
  input wire sil_pkg::sil_sample_t proxTwoSample,
  input wire sil_pkg::sil_resp_t commandResp,
  output logic irq,
  output logic intPinOut,
  output logic intPinOe
);
  import sil_pkg::*;

  logic rstMetaQ, rstMetaD;
  logic rstSyncQ, rstSyncD;

  // only the second stage reads the first
  always_comb begin
    rstMetaD = 1'b1;
    rstSyncD = rstMetaQ;
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMetaQ <= 1'b0;
      rstSyncQ <= 1'b0;
    end else begin
      rstMetaQ <= rstMetaD;
      rstSyncQ <= rstSyncD;
    end
  end

  // register state
  logic [1:0] intCfgQ, intCfgD;
  logic [5:0] eventEnQ, eventEnD;
  logic [7:0] modeOneQ, modeOneD;
  logic [7:0] modeTwoQ, modeTwoD;
  logic [5:0] statusQ, statusD;
  logic [7:0] proxOneThQ, proxOneThD;
  logic [7:0] proxTwoThQ, proxTwoThD;
  logic [7:0] proxHystQ, proxHystD;
  logic [7:0] proxPersistQ, proxPersistD;
  logic [31:0] prdataQ, prdataD;
  logic pslverrQ, pslverrD;
  logic [7:0] lastErrQ, lastErrD;
  logic cmdFlagQ, cmdFlagD;

  logic setupPhase, accessPhase, wrAccess, rdAccess;
  logic hitKnown;
  logic [31:0] readMux;
  logic proxOneSet, proxTwoSet;
  logic [5:0] setVec;
  logic pending;

  // layout guards: the fixed-width logic below cannot serve other layouts
  if (SIL_FLAG_W != 6) begin : g_flagWidth
    $error("status width must be six bits");
  end
  if (SIL_POS_PROX_ONE >= SIL_FLAG_W || SIL_POS_PROX_TWO >= SIL_FLAG_W
      || SIL_POS_COMMAND >= SIL_FLAG_W) begin : g_flagPos
    $error("event position outside the status register");
  end
  if (SIL_POS_PROX_ONE_SEL > 6 || SIL_POS_PROX_TWO_SEL > 6
      || SIL_POS_COMMAND_SEL > 7) begin : g_selPos
    $error("event select field outside its mode register");
  end
  if (SIL_POS_OUT_EN > 1 || SIL_POS_DEASSERT_MODE > 1) begin : g_cfgPos
    $error("configuration field outside its register");
  end
  if (SIL_ADDR_W != 10) begin : g_addrWidth
    $error("address must hold an 8-bit index and a byte offset");
  end

  // zero wait states: access always completes on its first edge
  assign pready = 1'b1;
  assign setupPhase = psel && !penable;
  assign accessPhase = psel && penable;
  assign wrAccess = accessPhase && pwrite;
  assign rdAccess = accessPhase && !pwrite;

  function automatic logic isReg(input logic [SIL_ADDR_W-1:0] a, input logic [7:0] idx);
    isReg = a == silAddr(idx);
  endfunction

  always_comb begin
    hitKnown = 1'b1;
    readMux = 32'h00000000;
    if (isReg(paddr, SIL_IDX_INT_CFG)) begin
      readMux = {30'h0, intCfgQ};
    end else if (isReg(paddr, SIL_IDX_EVENT_EN)) begin
      readMux = {26'h0, eventEnQ};
    end else if (isReg(paddr, SIL_IDX_MODE_ONE)) begin
      readMux = {24'h000000, modeOneQ};
    end else if (isReg(paddr, SIL_IDX_MODE_TWO)) begin
      readMux = {24'h000000, modeTwoQ};
    end else if (isReg(paddr, SIL_IDX_STATUS)) begin
      readMux = {26'h0, statusQ};
    end else if (isReg(paddr, SIL_IDX_PROX_ONE_TH)) begin
      readMux = {24'h000000, proxOneThQ};
    end else if (isReg(paddr, SIL_IDX_PROX_TWO_TH)) begin
      readMux = {24'h000000, proxTwoThQ};
    end else if (isReg(paddr, SIL_IDX_PROX_HYST)) begin
      readMux = {24'h000000, proxHystQ};
    end else if (isReg(paddr, SIL_IDX_PROX_PERSIST)) begin
      readMux = {24'h000000, proxPersistQ};
    end else begin
      hitKnown = 1'b0;
    end
  end

  // read data and error are captured in setup so they stand in access
  always_comb begin
    prdataD = prdataQ;
    pslverrD = pslverrQ;
    if (setupPhase) begin
      prdataD = pwrite ? 32'h00000000 : readMux;
      pslverrD = !hitKnown;
    end
  end

  always_comb begin
    intCfgD = intCfgQ;
    eventEnD = eventEnQ;
    modeOneD = modeOneQ;
    modeTwoD = modeTwoQ;
    proxOneThD = proxOneThQ;
    proxTwoThD = proxTwoThQ;
    proxHystD = proxHystQ;
    proxPersistD = proxPersistQ;
    if (wrAccess) begin
      if (isReg(paddr, SIL_IDX_INT_CFG)) begin
        intCfgD = pwdata[1:0];
      end
      if (isReg(paddr, SIL_IDX_EVENT_EN)) begin
        eventEnD = pwdata[5:0] & SIL_FLAG_USED;
      end
      if (isReg(paddr, SIL_IDX_MODE_ONE)) begin
        modeOneD = pwdata[7:0];
      end
      if (isReg(paddr, SIL_IDX_MODE_TWO)) begin
        modeTwoD = pwdata[7:0];
      end
      if (isReg(paddr, SIL_IDX_PROX_ONE_TH)) begin
        proxOneThD = pwdata[7:0];
      end
      if (isReg(paddr, SIL_IDX_PROX_TWO_TH)) begin
        proxTwoThD = pwdata[7:0];
      end
      if (isReg(paddr, SIL_IDX_PROX_HYST)) begin
        proxHystD = pwdata[7:0];
      end
      if (isReg(paddr, SIL_IDX_PROX_PERSIST)) begin
        proxPersistD = pwdata[7:0];
      end
    end
  end

  sil_prox_channel u_proxOne (
    .sysClk(sys_clk),
    .rstN(rstSyncQ),
    .sample(proxOneSample),
    .eventEn(eventEnQ[SIL_POS_PROX_ONE]),
    .eventSel(modeOneQ[SIL_POS_PROX_ONE_SEL +: 2]),
    .thresholdCode(proxOneThQ),
    .hysteresisCode(proxHystQ),
    .persistCount(proxPersistQ),
    .setFlag(proxOneSet)
  );

  sil_prox_channel u_proxTwo (
    .sysClk(sys_clk),
    .rstN(rstSyncQ),
    .sample(proxTwoSample),
    .eventEn(eventEnQ[SIL_POS_PROX_TWO]),
    .eventSel(modeOneQ[SIL_POS_PROX_TWO_SEL +: 2]),
    .thresholdCode(proxTwoThQ),
    .hysteresisCode(proxHystQ),
    .persistCount(proxPersistQ),
    .setFlag(proxTwoSet)
  );

  // command events, registered to line up with the channel flags
  always_comb begin
    lastErrD = lastErrQ;
    cmdFlagD = 1'b0;
    if (commandResp.valid) begin
      if (!modeTwoQ[SIL_POS_COMMAND_SEL]) begin
        cmdFlagD = eventEnQ[SIL_POS_COMMAND];
      end else begin
        cmdFlagD = eventEnQ[SIL_POS_COMMAND] && commandResp.code[SIL_POS_RESP_ERR]
                   && commandResp.code != lastErrQ;
      end
      lastErrD = commandResp.code;
    end
  end

  always_comb begin
    setVec = 6'h00;
    setVec[SIL_POS_PROX_ONE] = proxOneSet;
    setVec[SIL_POS_PROX_TWO] = proxTwoSet;
    setVec[SIL_POS_COMMAND] = cmdFlagQ;
    statusD = statusQ;
    if (wrAccess && isReg(paddr, SIL_IDX_STATUS) && !intCfgQ[SIL_POS_DEASSERT_MODE]) begin
      statusD = statusQ & ~pwdata[5:0];
    end
    // other deassert mode: a read clears only what it reported, so a flag
    // raised between setup and access is not lost unseen
    if (rdAccess && isReg(paddr, SIL_IDX_STATUS) && intCfgQ[SIL_POS_DEASSERT_MODE]) begin
      statusD = statusQ & ~prdataQ[5:0];
    end
    // a new event in the clearing cycle survives
    statusD = statusD | setVec;
  end

  // configuration registers
  always_ff @(posedge sys_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      intCfgQ <= SIL_RST_INT_CFG;
      eventEnQ <= SIL_RST_EVENT_EN;
      modeOneQ <= SIL_RST_MODE;
      modeTwoQ <= SIL_RST_MODE;
      proxOneThQ <= SIL_RST_TH;
      proxTwoThQ <= SIL_RST_TH;
      proxHystQ <= SIL_RST_HYST;
      proxPersistQ <= SIL_RST_PERSIST;
    end else begin
      intCfgQ <= intCfgD;
      eventEnQ <= eventEnD;
      modeOneQ <= modeOneD;
      modeTwoQ <= modeTwoD;
      proxOneThQ <= proxOneThD;
      proxTwoThQ <= proxTwoThD;
      proxHystQ <= proxHystD;
      proxPersistQ <= proxPersistD;
    end
  end

  // read path
  always_ff @(posedge sys_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      prdataQ <= 32'h00000000;
      pslverrQ <= 1'b0;
    end else begin
      prdataQ <= prdataD;
      pslverrQ <= pslverrD;
    end
  end

  // command tracking
  always_ff @(posedge sys_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      lastErrQ <= 8'h00;
      cmdFlagQ <= 1'b0;
    end else begin
      lastErrQ <= lastErrD;
      cmdFlagQ <= cmdFlagD;
    end
  end

  // event flags
  always_ff @(posedge sys_clk or negedge rstSyncQ) begin
    if (!rstSyncQ) begin
      statusQ <= 6'h00;
    end else begin
      statusQ <= statusD;
    end
  end

  assign prdata = prdataQ;
  assign pslverr = pslverrQ && accessPhase;
  assign pending = |(statusQ & eventEnQ);
  assign irq = pending;
  // open drain, active low: pin pulled low only while enabled
  assign intPinOut = 1'b0;
  assign intPinOe = pending && intCfgQ[SIL_POS_OUT_EN];

endmodule

// >>> verif/sil_irq_props.sv
`timescale 1ns/1ps
module sil_irq_props (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [sil_pkg::SIL_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire sil_pkg::sil_sample_t proxOneSample,
  input wire sil_pkg::sil_sample_t proxTwoSample,
  input wire sil_pkg::sil_resp_t commandResp,
  input wire logic irq,
  input wire logic intPinOut,
  input wire logic intPinOe
);
  import sil_pkg::*;
  logic acc;
  logic outEnQ;
  logic cmdSelQ;
  logic [5:0] enQ;
  logic [7:0] modeQ;
  assign acc = psel && penable;
  // shadows of the gating registers, taken from bus writes
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      outEnQ <= 1'b0;
      cmdSelQ <= 1'b0;
      enQ <= 6'h00;
      modeQ <= 8'h00;
    end else if (acc && pwrite) begin
      if (paddr == silAddr(SIL_IDX_INT_CFG)) outEnQ <= pwdata[0];
      if (paddr == silAddr(SIL_IDX_MODE_TWO)) cmdSelQ <= pwdata[2];
      if (paddr == silAddr(SIL_IDX_EVENT_EN)) enQ <= pwdata[5:0] & SIL_FLAG_USED;
      if (paddr == silAddr(SIL_IDX_MODE_ONE)) modeQ <= pwdata[7:0];
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_pin_low: assert property (!intPinOut) else $error("pin drives high");
  a_pin_gated: assert property (intPinOe == (irq && outEnQ))
    else $error("pin enable wrong");
  a_irq_masked: assert property (irq |-> enQ != 6'h00) else $error("irq unmasked");
  a_irq_cause: assert property ($rose(irq) |-> $past(acc) || $past(commandResp.valid, 2)
    || $past(proxOneSample.valid, 2) || $past(proxTwoSample.valid, 2))
    else $error("irq rose without cause");
  a_irq_sticky: assert property (irq && !acc |=> irq) else $error("irq dropped");
  a_one_every: assert property (proxOneSample.valid && enQ[2] && modeQ[5:4] == 2'h0
    ##1 !acc [*2] |-> irq) else $error("channel one flag missing");
  a_two_every: assert property (proxTwoSample.valid && enQ[3] && modeQ[7:6] == 2'h0
    ##1 !acc [*2] |-> irq) else $error("channel two flag missing");
  a_cmd_every: assert property (commandResp.valid && enQ[5] && !cmdSelQ
    ##1 !acc [*2] |-> irq) else $error("command flag missing");
endmodule
bind sil_irq_core sil_irq_props u_props (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq(irq),
  .proxOneSample(proxOneSample), .proxTwoSample(proxTwoSample), .commandResp(commandResp),
  .intPinOut(intPinOut), .intPinOe(intPinOe));

// >>> verif/sil_host_model.sv
`timescale 1ns/1ps
module sil_host_model (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic wr,
  input wire logic [9:0] addr,
  input wire logic [31:0] wdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [9:0] paddr = 10'h000,
  output logic [31:0] pwdata = 32'h0,
  output logic done = 1'b0,
  output logic [31:0] rdata,
  output logic err
);
  always @(posedge sys_clk) begin
    done <= 1'b0;
    if (!psel && go) begin
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wdata;
    end else if (psel && !penable) begin
      penable <= 1'b1;
    end else if (penable && pready) begin
      // read word kept whole so it can be written back
      psel <= 1'b0;
      penable <= 1'b0;
      rdata <= prdata;
      err <= pslverr;
      done <= 1'b1;
    end
  end
endmodule

// >>> verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sil_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic wr = 1'b0;
  logic [9:0] addr = 10'h000;
  logic [31:0] wdata = 32'h0;
  logic psel, penable, pwrite, pready, pslverr, irq, intPinOut, intPinOe, done, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  sil_sample_t s1 = '0;
  sil_sample_t s2 = '0;
  sil_resp_t cr = '0;
  int nMismatch = 0;
  int checkCount = 0;
  int seed = 45;
  int th, hy;
  logic st, nst;
  logic [1:0] ex;
  logic [15:0] v;
  always #12.5 sys_clk = ~sys_clk;
  sil_host_model host (.sys_clk(sys_clk), .go(go), .wr(wr), .addr(addr), .wdata(wdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .done(done), .rdata(rdata), .err(err));
  sil_irq_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .proxOneSample(s1), .proxTwoSample(s2), .commandResp(cr),
    .irq(irq), .intPinOut(intPinOut), .intPinOe(intPinOe));
  function automatic int xp(logic [7:0] c);
    return c[7:4] == 4'h0 ? int'(c[3:0]) : (16 + int'(c[3:0])) << (int'(c[7:4]) - 1);
  endfunction
  task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic acc(logic w, logic [7:0] idx, logic [31:0] d);
    @(posedge sys_clk);
    go <= 1'b1;
    wr <= w;
    addr <= silAddr(idx);
    wdata <= d;
    @(posedge sys_clk);
    go <= 1'b0;
    while (!done) @(posedge sys_clk);
  endtask
  task automatic rd(string n, logic [7:0] idx, logic [31:0] exp);
    acc(1'b0, idx, 32'h0);
    check(n, rdata, exp);
  endtask
  task automatic clr;
    acc(1'b0, SIL_IDX_STATUS, 32'h0);
    acc(1'b1, SIL_IDX_STATUS, rdata);
  endtask
  task automatic fire(int ch, logic [15:0] val);
    @(posedge sys_clk);
    if (ch == 1) s1 <= '{1'b1, val};
    else if (ch == 2) s2 <= '{1'b1, val};
    else cr <= '{1'b1, val[7:0]};
    @(posedge sys_clk);
    s1.valid <= 1'b0;
    s2.valid <= 1'b0;
    cr.valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask
  task automatic do_reset;
    rst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checkCount, nMismatch);
    if (nMismatch == 0 && checkCount > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    do_reset();
    rd("cfg", SIL_IDX_INT_CFG, 32'h0);
    acc(1'b0, 8'hff, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    acc(1'b1, SIL_IDX_EVENT_EN, 32'hffffffff);
    rd("enable", SIL_IDX_EVENT_EN, 32'h2c);
    acc(1'b1, SIL_IDX_INT_CFG, 32'h1);
    $display("registers done");
    fire(1, 16'($random(seed)));
    fire(2, 16'($random(seed)));
    fire(3, 16'h0005);
    rd("status", SIL_IDX_STATUS, 32'h2c);
    check("pin on", {31'h0, intPinOe}, 32'h1);
    check("pin level", {31'h0, intPinOut}, 32'h0);
    check("ready", {31'h0, pready}, 32'h1);
    acc(1'b1, SIL_IDX_STATUS, 32'h0);
    rd("status kept", SIL_IDX_STATUS, 32'h2c);
    acc(1'b1, SIL_IDX_INT_CFG, 32'h0);
    check("pin off", {31'h0, intPinOe}, 32'h0);
    clr();
    rd("cleared", SIL_IDX_STATUS, 32'h0);
    check("irq low", {31'h0, irq}, 32'h0);
    acc(1'b1, SIL_IDX_EVENT_EN, 32'h28);
    fire(1, 16'h1234);
    rd("disabled", SIL_IDX_STATUS, 32'h0);
    $display("every sample done");
    for (int m = 0; m < 2; m++) begin
      do_reset();
      acc(1'b1, SIL_IDX_EVENT_EN, 32'h0c);
      acc(1'b1, SIL_IDX_MODE_ONE, m ? 32'h70 : 32'hd0);
      acc(1'b1, SIL_IDX_PROX_ONE_TH, 32'h21);
      acc(1'b1, SIL_IDX_PROX_TWO_TH, 32'h21);
      acc(1'b1, SIL_IDX_PROX_HYST, 32'h02);
      th = xp(8'h21);
      hy = xp(8'h02);
      st = 1'b0;
      repeat (12) begin
        v = 16'(29 + ($random(seed) & 15));
        fire(1, v);
        fire(2, v);
        nst = v > th + hy ? 1'b1 : v < th - hy ? 1'b0 : st;
        ex = m ? {nst != st, nst} : {nst, nst != st};
        rd("threshold", SIL_IDX_STATUS, {28'h0, ex, 2'b00});
        clr();
        st = nst;
      end
    end
    $display("threshold done");
    do_reset();
    acc(1'b1, SIL_IDX_EVENT_EN, 32'h04);
    acc(1'b1, SIL_IDX_MODE_ONE, 32'h30);
    acc(1'b1, SIL_IDX_PROX_ONE_TH, 32'h21);
    acc(1'b1, SIL_IDX_PROX_HYST, 32'h02);
    acc(1'b1, SIL_IDX_PROX_PERSIST, 32'h02);
    fire(1, 16'(th + hy + 1));
    rd("one sample", SIL_IDX_STATUS, 32'h0);
    fire(1, 16'(th + hy + 1));
    rd("second sample", SIL_IDX_STATUS, 32'h04);
    $display("persistence done");
    do_reset();
    acc(1'b1, SIL_IDX_EVENT_EN, 32'h04);
    acc(1'b1, SIL_IDX_INT_CFG, 32'h3);
    fire(1, 16'($random(seed)));
    acc(1'b1, SIL_IDX_STATUS, 32'h3f);
    check("pin held", {31'h0, intPinOe}, 32'h1);
    rd("read clears", SIL_IDX_STATUS, 32'h04);
    rd("after read", SIL_IDX_STATUS, 32'h0);
    check("irq off", {31'h0, irq}, 32'h0);
    $display("read clear done");
    do_reset();
    acc(1'b1, SIL_IDX_EVENT_EN, 32'h20);
    acc(1'b1, SIL_IDX_MODE_TWO, 32'h04);
    fire(3, 16'h0005);
    rd("no error", SIL_IDX_STATUS, 32'h0);
    fire(3, 16'h0088);
    rd("new error", SIL_IDX_STATUS, 32'h20);
    clr();
    fire(3, 16'h0088);
    rd("same error", SIL_IDX_STATUS, 32'h0);
    $display("command done");
    wrap_up();
  end
  initial begin
    #400000;
    nMismatch++;
    wrap_up();
  end
endmodule
